/* hdl/ecp_pkg.sv */
// constants of the encoder counter with preset and capture
package ecp_pkg;
	localparam int          CNT_W        = 16;
	localparam logic [15:0] CNT_MAX      = 16'hFFFF;
	localparam logic [15:0] UP_CLR_FROM  = 16'h5555;
	localparam logic [15:0] UP_CLR_TO    = 16'h5556;
	localparam logic [15:0] DN_CLR_FROM  = 16'hAAAA;
	localparam logic [15:0] DN_CLR_TO    = 16'hAAA9;
	localparam logic [15:0] CNT_RST      = 16'h0000;
	// register addresses
	localparam logic [3:0]  ADDR_CTRL    = 4'h0;
	localparam logic [3:0]  ADDR_STAT    = 4'h1;
	localparam logic [3:0]  ADDR_DATA    = 4'h2;
	localparam logic [3:0]  ADDR_COUNT   = 4'h3;
	localparam logic [3:0]  ADDR_CAPT    = 4'h4;
	localparam logic [3:0]  ADDR_IRQ_ST  = 4'h5;
	localparam logic [3:0]  ADDR_IRQ_MSK = 4'h6;
	// control byte fields
	localparam int          CTL_IDX_ARM  = 0;
	localparam int          CTL_EXT_ARM  = 1;
	localparam int          CTL_PRESET   = 2;
	localparam int          CTL_FAST     = 5;
	// status byte fields
	localparam int          ST_IDX_DONE  = 0;
	localparam int          ST_EXT_DONE  = 1;
	localparam int          ST_PRE_DONE  = 2;
	localparam int          ST_DN_WRAP   = 3;
	localparam int          ST_UP_WRAP   = 4;
endpackage

/* hdl/ecp_counter.sv */
// encoder counter with preset, capture, wrap flags and interrupt
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
// Operation
// - count is a 16-bit unsigned value, maximum 65535
// - rising preset request outside fast mode loads data word into count, sets preset done
// - armed external capture outside fast mode copies count on rising capture input
// - completed external capture sets external capture done
// - armed index capture outside fast mode copies count on rising index input
// - completed index capture sets index capture done
// - up wrap set on 65535 to 0; cleared at 21845->21846 or down wrap
// - down wrap set on 0 to 65535; cleared at 43690->43689 or up wrap
// - active gate holds the count except on a preset load
module ecp_counter (
	input  wire logic        mclk,
	input  wire logic        srst,
	input  wire logic        enc_a,
	input  wire logic        enc_b,
	input  wire logic        enc_index,
	input  wire logic        ext_capture,
	input  wire logic        gate,
	input  wire logic [3:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [15:0] rdata,
	output logic             irq
);
	////////////////////////////////////////////////////////////////////////////
	// input synchronisers
	logic [4:0] sync1;
	logic [4:0] sync2;
	logic [4:0] prev;
	always_ff @(posedge mclk) begin
		sync1 <= {gate, ext_capture, enc_index, enc_b, enc_a};
		sync2 <= sync1;
		prev  <= sync2;
	end
	wire logic a_s   = sync2[0];
	wire logic b_s   = sync2[1];
	wire logic idx_r = sync2[2] & ~prev[2];
	wire logic ext_r = sync2[3] & ~prev[3];
	wire logic gate_s = sync2[4];

	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [7:0]  ctrl;
	logic [7:0]  ctrl_q;
	logic [15:0] data_word;
	logic [15:0] count;
	logic [15:0] capt;
	logic        up_wrap;
	logic        dn_wrap;
	logic        pre_done;
	logic        ext_done;
	logic        idx_done;
	logic [4:0]  irq_st;
	logic [4:0]  irq_msk;

	////////////////////////////////////////////////////////////////////////////
	// quadrature decode
	wire logic a_chg  = a_s ^ prev[0];
	wire logic b_chg  = b_s ^ prev[1];
	wire logic step   = (a_chg ^ b_chg) & ~gate_s;
	wire logic dir_up = a_chg ? (a_s ^ b_s) : ~(a_s ^ b_s);
	wire logic fast   = ctrl[ecp_pkg::CTL_FAST];

	wire logic pre_req  = ctrl[ecp_pkg::CTL_PRESET];
	wire logic ext_arm  = ctrl[ecp_pkg::CTL_EXT_ARM];
	wire logic idx_arm  = ctrl[ecp_pkg::CTL_IDX_ARM];
	wire logic pre_rise = pre_req & ~ctrl_q[ecp_pkg::CTL_PRESET] & ~fast;
	wire logic ext_hit  = ext_arm & ~ext_done & ext_r & ~fast;
	wire logic idx_hit  = idx_arm & ~idx_done & idx_r & ~fast;

	wire logic [15:0] cnt_inc = count + 16'h0001;
	wire logic [15:0] cnt_dec = count - 16'h0001;
	wire logic [15:0] next_count = pre_rise ? data_word :
		(step ? (dir_up ? cnt_inc : cnt_dec) : count);
	wire logic up_ev = ~pre_rise & step & dir_up & (count == ecp_pkg::CNT_MAX);
	wire logic dn_ev = ~pre_rise & step & ~dir_up & (count == ecp_pkg::CNT_RST);
	wire logic up_clr = ~pre_rise & step & dir_up & (count == ecp_pkg::UP_CLR_FROM);
	wire logic dn_clr = ~pre_rise & step & ~dir_up & (count == ecp_pkg::DN_CLR_FROM);

	wire logic [4:0] events = {up_ev, dn_ev, pre_rise, ext_hit, idx_hit};
	wire logic sel_ctrl = addr == ecp_pkg::ADDR_CTRL;
	wire logic sel_data = addr == ecp_pkg::ADDR_DATA;
	wire logic sel_ist  = addr == ecp_pkg::ADDR_IRQ_ST;
	wire logic sel_msk  = addr == ecp_pkg::ADDR_IRQ_MSK;
	wire logic [7:0] status = {3'h0, up_wrap, dn_wrap, pre_done, ext_done, idx_done};
	wire logic [15:0] next_rdata =
		sel_ctrl ? {8'h00, ctrl} :
		(addr == ecp_pkg::ADDR_STAT) ? {8'h00, status} :
		sel_data ? data_word :
		(addr == ecp_pkg::ADDR_COUNT) ? count :
		(addr == ecp_pkg::ADDR_CAPT) ? capt :
		sel_ist ? {11'h000, irq_st} :
		sel_msk ? {11'h000, irq_msk} : 16'h0000;

	////////////////////////////////////////////////////////////////////////////
	// register file and counter
	always_ff @(posedge mclk) begin
		if (srst) begin
			ctrl      <= 8'h00;
			ctrl_q    <= 8'h00;
			data_word <= 16'h0000;
			irq_msk   <= 5'h00;
			rdata     <= 16'h0000;
		end else begin
			ctrl_q <= ctrl;
			if (wr && sel_ctrl)
				ctrl <= {1'b0, wdata[6:0]};
			if (wr && sel_data)
				data_word <= wdata;
			if (wr && sel_msk)
				irq_msk <= wdata[4:0];
			rdata <= rd ? next_rdata : 16'h0000;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			count <= ecp_pkg::CNT_RST;
			capt  <= 16'h0000;
		end else begin
			count <= next_count;
			if (ext_hit || idx_hit)
				capt <= count;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			up_wrap  <= 1'b0;
			dn_wrap  <= 1'b0;
			pre_done <= 1'b0;
			ext_done <= 1'b0;
			idx_done <= 1'b0;
		end else begin
			up_wrap  <= up_ev | (up_wrap & ~dn_ev & ~up_clr);
			dn_wrap  <= dn_ev | (dn_wrap & ~up_ev & ~dn_clr);
			pre_done <= pre_rise | (pre_done & pre_req);
			ext_done <= ext_hit | (ext_done & ext_arm);
			idx_done <= idx_hit | (idx_done & idx_arm);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt
	always_ff @(posedge mclk) begin
		if (srst) begin
			irq_st <= 5'h00;
			irq    <= 1'b0;
		end else begin
			irq_st <= events | (irq_st & ~((wr && sel_ist) ? wdata[4:0] : 5'h00));
			irq    <= |(irq_st & irq_msk);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	preset_load_a: assert property (@(posedge mclk) disable iff (srst)
		pre_rise |=> (count == $past(data_word)) && pre_done)
		else $error("preset not loaded");
	ext_capt_a: assert property (@(posedge mclk) disable iff (srst)
		ext_hit |=> (capt == $past(count)) && ext_done)
		else $error("external capture wrong");
	ext_done_a: assert property (@(posedge mclk) disable iff (srst)
		$rose(ext_done) |-> $past(ext_arm) && $past(ext_r))
		else $error("external done without cause");
	idx_capt_a: assert property (@(posedge mclk) disable iff (srst)
		idx_hit |=> (capt == $past(count)) && idx_done)
		else $error("index capture wrong");
	idx_done_a: assert property (@(posedge mclk) disable iff (srst)
		$rose(idx_done) |-> $past(idx_arm) && $past(idx_r))
		else $error("index done without cause");
	up_wrap_a: assert property (@(posedge mclk) disable iff (srst)
		up_ev |=> up_wrap && !dn_wrap && count == 16'h0000)
		else $error("upward wrap flag wrong");
	dn_wrap_a: assert property (@(posedge mclk) disable iff (srst)
		dn_ev |=> dn_wrap && !up_wrap && count == 16'hFFFF)
		else $error("downward wrap flag wrong");
	gate_hold_a: assert property (@(posedge mclk) disable iff (srst)
		gate_s && !pre_rise |=> $stable(count))
		else $error("count moved while gated");
	done_clr_a: assert property (@(posedge mclk) disable iff (srst)
		!pre_req && !pre_rise |=> !pre_done)
		else $error("preset done not cleared");
	step_up_a: assert property (@(posedge mclk) disable iff (srst)
		step && dir_up && !pre_rise |=> count == $past(count) + 16'h0001)
		else $error("up step wrong");
	step_dn_a: assert property (@(posedge mclk) disable iff (srst)
		step && !dir_up && !pre_rise |=> count == $past(count) - 16'h0001)
		else $error("down step wrong");
	no_step_a: assert property (@(posedge mclk) disable iff (srst)
		!step && !pre_rise |=> $stable(count))
		else $error("count moved without step");
	up_clr_a: assert property (@(posedge mclk) disable iff (srst)
		up_clr |=> !up_wrap && count == ecp_pkg::UP_CLR_TO)
		else $error("upward wrap not cleared");
	dn_clr_a: assert property (@(posedge mclk) disable iff (srst)
		dn_clr |=> !dn_wrap && count == ecp_pkg::DN_CLR_TO)
		else $error("downward wrap not cleared");
	ext_clr_a: assert property (@(posedge mclk) disable iff (srst)
		!ext_arm |=> !ext_done)
		else $error("external done not cleared");
	idx_clr_a: assert property (@(posedge mclk) disable iff (srst)
		!idx_arm |=> !idx_done)
		else $error("index done not cleared");
	capt_hold_a: assert property (@(posedge mclk) disable iff (srst)
		!ext_hit && !idx_hit |=> $stable(capt))
		else $error("capture changed without trigger");
	cov_preset_c: cover property (@(posedge mclk) pre_rise);
	cov_ext_c: cover property (@(posedge mclk) ext_hit);
	cov_idx_c: cover property (@(posedge mclk) idx_hit);
	cov_wrap_c: cover property (@(posedge mclk) up_ev ##[1:100] dn_ev);
endmodule // ecp_counter
`default_nettype wire

/* dv/ecp_enc_model.sv */
// quadrature encoder model with index output
`timescale 1ns/1ns
`default_nettype none
module ecp_enc_model (
	input  wire logic mclk,
	input  wire logic step,
	input  wire logic up,
	input  wire logic idx_req,
	output logic      enc_a,
	output logic      enc_b,
	output logic      enc_index
);
	logic [1:0] ph = 2'h0;
	// one quadrature state per step
	always @(posedge mclk) begin
		if (step) begin
			ph <= up ? ph + 2'h1 : ph - 2'h1;
		end
	end
	// a leads b going up
	assign enc_a = ph[0] ^ ph[1];
	assign enc_b = ph[1];
	assign enc_index = idx_req;
endmodule // ecp_enc_model
`default_nettype wire

/* dv/encoder_counter_preset_latch_tb.sv */
// testbench of the encoder counter
`timescale 1ns/1ns
`default_nettype none
module encoder_counter_preset_latch_tb;
	logic        mclk = 1'b0;
	logic        srst = 1'b1;
	logic        ext_capture = 1'b0;
	logic        gate = 1'b0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic        step = 1'b0;
	logic        up = 1'b1;
	logic        idx_req = 1'b0;
	logic [3:0]  addr = 4'h0;
	logic [15:0] wdata = 16'h0000;
	logic [15:0] rdata;
	logic        irq;
	logic        enc_a;
	logic        enc_b;
	logic        enc_index;
	int          error_cnt = 0;
	int          samples_checked = 0;
	always #5 mclk = ~mclk;
	ecp_enc_model ecp_enc_model_i (.mclk(mclk), .step(step), .up(up), .idx_req(idx_req),
		.enc_a(enc_a), .enc_b(enc_b), .enc_index(enc_index));
	ecp_counter ecp_counter_i (.mclk(mclk), .srst(srst), .enc_a(enc_a), .enc_b(enc_b),
		.enc_index(enc_index), .ext_capture(ext_capture), .gate(gate), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .irq(irq));
	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic steps(input int n, input logic dir);
		repeat (n) begin
			@(posedge mclk);
			up <= dir;
			step <= 1'b1;
			@(posedge mclk);
			step <= 1'b0;
			repeat (6) @(posedge mclk);
		end
	endtask
	task automatic pin(input logic ext);
		@(posedge mclk);
		ext_capture <= ext;
		idx_req <= !ext;
		repeat (4) @(posedge mclk);
		ext_capture <= 1'b0;
		idx_req <= 1'b0;
		repeat (6) @(posedge mclk);
	endtask
	task automatic preset(input logic [15:0] v);
		wr_reg(ecp_pkg::ADDR_DATA, v);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0004);
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0000);
		rd_chk(4'hF, 16'h0000);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0080);
		rd_chk(ecp_pkg::ADDR_CTRL, 16'h0000);
		wr_reg(ecp_pkg::ADDR_DATA, 16'hFFFE);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0004);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'hFFFE);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0004);
		steps(3, 1'b1);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'h0001);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0000);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0010);
		steps(2, 1'b0);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'hFFFF);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0008);
		chk({15'h0000, irq}, 16'h0000);
		gate <= 1'b1;
		steps(2, 1'b1);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'hFFFF);
		gate <= 1'b0;
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0002);
		pin(1'b1);
		rd_chk(ecp_pkg::ADDR_CAPT, 16'hFFFF);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h000A);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0001);
		steps(1, 1'b1);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0010);
		pin(1'b0);
		rd_chk(ecp_pkg::ADDR_CAPT, 16'h0000);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0011);
		wr_reg(ecp_pkg::ADDR_IRQ_MSK, 16'h001F);
		#1 chk({15'h0000, irq}, 16'h0001);
		rd_chk(ecp_pkg::ADDR_IRQ_ST, 16'h001F);
		wr_reg(ecp_pkg::ADDR_IRQ_ST, 16'h001F);
		#1 chk({15'h0000, irq}, 16'h0000);
		// wrap flag clearing at the one-third and two-thirds crossings
		preset(16'h5555);
		steps(1, 1'b1);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0004);
		preset(16'h0000);
		steps(1, 1'b0);
		preset(16'hAAAA);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h000C);
		steps(1, 1'b0);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'hAAA9);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0004);
		// fast mode: preset and capture ignored, counting goes on
		wr_reg(ecp_pkg::ADDR_DATA, 16'h1234);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0020);
		wr_reg(ecp_pkg::ADDR_CTRL, 16'h0025);
		steps(1, 1'b1);
		pin(1'b0);
		rd_chk(ecp_pkg::ADDR_COUNT, 16'hAAAA);
		rd_chk(ecp_pkg::ADDR_CAPT, 16'h0000);
		rd_chk(ecp_pkg::ADDR_STAT, 16'h0000);
		// reset in mid-run
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		srst <= 1'b0;
		rd_chk(ecp_pkg::ADDR_COUNT, 16'h0000);
		rd_chk(ecp_pkg::ADDR_CTRL, 16'h0000);
		end_of_test();
	end
endmodule // encoder_counter_preset_latch_tb
`default_nettype wire
